// *** rtl/slt_pkg.sv ***
// Shared constants for the serial link transmit control and receive framer.
// Assumes one 100 MHz pclk domain; pins are synchronised in the top module.
package slt_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_RXCH = 8'h08;
  localparam logic [7:0] ADDR_TXCH = 8'h0C;

  // Control register fields
  localparam int CTRL_SPEED   = 0;
  localparam int CTRL_RANGE   = 1;
  localparam int CTRL_CWIDTH  = 2;
  localparam int CTRL_FIFOBYN = 3;
  localparam int CTRL_ENCBYN  = 4;
  localparam int CTRL_LOOP    = 5;
  localparam int CTRL_LINESEL = 6;
  localparam int CTRL_FRAMEN  = 7;
  localparam logic [7:0] CTRL_RESET = 8'h1C;

  // Status register fields
  localparam int STAT_FAULT = 0;
  localparam int STAT_TRACK = 1;
  localparam int STAT_HALT  = 2;
  localparam int STAT_MULT  = 8;

  // ----------------------------------------------------------------------
  // Bit-clock multiplier in half-bits per reference period
  // ----------------------------------------------------------------------
  localparam logic [7:0] HU_25X    = 8'h05;
  localparam logic [7:0] HU_5X     = 8'h0A;
  localparam logic [7:0] HU_10X    = 8'h14;
  localparam logic [7:0] HU_3X     = 8'h06;
  localparam logic [7:0] HU_6X     = 8'h0C;
  localparam logic [7:0] HU_12X    = 8'h18;
  localparam logic [7:0] HU_PERBIT = 8'h02;

  // Character lengths in bits
  localparam logic [3:0] LEN_10 = 4'hA;
  localparam logic [3:0] LEN_12 = 4'hC;

  typedef enum logic [1:0] {
    TX_BYPASS,
    TX_FIFO,
    TX_HALTED
  } slt_tx_state_t;

endpackage

// *** rtl/slt_char_div.sv ***
// Free-running character divider: counts bit ticks modulo the char length.
// Assumes bit_tick is a one-cycle strobe on pclk.
module slt_char_div (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // Bit timing
  input  wire logic       bit_tick,
  input  wire logic [3:0] len,
  // Character timing
  output logic      [3:0] cnt,
  output logic            char_tick
);

  typedef struct packed {
    logic [3:0] cnt;
  } slt_div_st_t;

  slt_div_st_t st_ff;
  slt_div_st_t nxt_st;
  logic        at_last;

  // Wraps also when len shrinks below the current count
  assign at_last   = (st_ff.cnt >= (len - 4'h1));
  assign char_tick = bit_tick & at_last;
  assign cnt       = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    if (bit_tick) begin
      nxt_st.cnt = at_last ? 4'h0 : st_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div_wrap: assert property (
    ce && char_tick |=> st_ff.cnt == 4'h0)
    else $error("divider did not wrap on char tick");

endmodule

// *** rtl/slt_framer.sv ***
// Receive framer: hunts the sync character at every bit offset and picks
// characters out at the fixed divider boundary, shifted by a stored offset.
// Assumes bits arrive LSB first, one per bit_tick.
module slt_framer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // Bit stream
  input  wire logic        bit_tick,
  input  wire logic        bit_in,
  // Framing control
  input  wire logic        enable,
  input  wire logic [3:0]  len,
  input  wire logic [3:0]  cnt,
  input  wire logic        char_tick,
  input  wire logic [11:0] sync_pat,
  // Framed characters
  output logic      [11:0] char_out,
  output logic             char_valid
);

  typedef struct packed {
    logic [23:0] hist;
    logic [3:0]  off;
    logic [11:0] ch;
    logic        vld;
  } slt_frm_st_t;

  slt_frm_st_t st_ff;
  slt_frm_st_t nxt_st;
  logic [23:0] hist_n;
  logic [11:0] mask;
  logic [11:0] newest;
  logic        match;

  assign hist_n   = {bit_in, st_ff.hist[23:1]};
  assign mask     = (len == slt_pkg::LEN_12) ? 12'hFFF : 12'h3FF;
  assign newest   = 12'(hist_n >> (5'd24 - {1'b0, len})) & mask;
  assign match    = (newest == (sync_pat & mask));
  assign char_out = st_ff.ch;
  assign char_valid = st_ff.vld;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.vld = 1'b0;
    if (bit_tick) begin
      nxt_st.hist = hist_n;
      if (enable && match) begin
        nxt_st.off = len - 4'h1 - cnt;
      end
      if (char_tick) begin
        nxt_st.ch  = 12'(hist_n >> (5'd24 - {1'b0, len} - {1'b0, nxt_st.off}))
                     & mask;
        nxt_st.vld = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_frame_hold: assert property (
    ce && !enable |=> st_ff.off == $past(st_ff.off))
    else $error("boundary moved with framer disabled");

  a_frame_align: assert property (
    ce && enable && bit_tick && match
    |=> st_ff.off == $past(len) - 4'h1 - $past(cnt))
    else $error("offset not taken from sync position");

  a_sync_out: assert property (
    ce && enable && bit_tick && match && char_tick
    |=> st_ff.vld && st_ff.ch == ($past(sync_pat) & $past(mask)))
    else $error("aligned sync not delivered on the same char tick");

endmodule

// *** rtl/slt_top.sv ***
// Serial link control: bit/char clock multiplier, transmit control machine,
// shifter, receive line select, signal detect, divider and framer, with an
// APB register slave. Assumes an external encoder answering combinationally
// and a first-word-fall-through transmit FIFO gated by the same ce.
//
// Our own choices: the register addresses and the APB slave port.

// Function
// - Bit clock is reference times 2.5, 5, 10, or 3, 6, 12 coded twelve-bit
// - A character-rate clock from the same multiplier steps the transmit machine
// - Speed picks 50-100 or 100-200 MBaud; range picks reference band
// - Speed low with FIFO bypassed forces range select to low
// - FIFO bypassed: machine runs on reference, input goes straight to pipeline (here the machine still steps on the multiplier char tick)
// - Halt counts only with FIFO enabled and is ignored with FIFO bypassed
// - Halt stops at next FIFO character; no reads until released
// - Line select picks one of two inputs; loopback picks own serializer
// - Signal valid only with amplitude, density, carrier and frequency good
// - Link fault changes only on the receive character clock
// - Recovery follows reference while received frequency is out of range
// - Free-running receive divider gives bit rate over ten or twelve
// - With FIFO bypassed a divider clock drives the receive clock out
// - Enabled framer finds sync at any offset and fixes boundaries
// - Framer enable high may realign on sync; low keeps boundaries
// - Realignment moves character position, never the character clock phase
// - Characters go out LSB first; framer assumes the same
// - Encoder bypass low passes ten or twelve bit characters unchanged
module slt_top #(
  parameter logic [9:0]  SYNC_10B = 10'h0F8,
  parameter logic [11:0] SYNC_12B = 12'h0FC
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous pins
  input  wire logic        reference_clock,
  input  wire logic        serial_in_primary,
  input  wire logic        serial_in_secondary,
  input  wire logic        tx_halt_a,
  input  wire logic        sig_amplitude_ok,
  input  wire logic        sig_density_ok,
  input  wire logic        sig_carrier_ok,
  input  wire logic        sig_freq_ok,
  // Host transmit side
  input  wire logic [11:0] tx_parallel_data,
  input  wire logic        tx_parallel_cmd,
  input  wire logic        tx_write_enable,
  input  wire logic        tx_full_flag,
  input  wire logic [11:0] tx_fifo_data,
  input  wire logic        tx_fifo_cmd,
  input  wire logic        tx_fifo_empty,
  output logic             tx_fifo_read,
  // Encoder
  output logic      [11:0] enc_char,
  output logic             enc_is_cmd,
  input  wire logic [11:0] enc_code_in,
  // Line and receive side
  output logic             serial_out,
  output logic             rx_char_clock,
  output logic      [11:0] rx_char_out,
  output logic             rx_char_valid,
  output logic             link_fault,
  output logic             cdr_track_ref
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            sy1;
    logic [7:0]            sy2;
    logic                  ref_d;
    logic [7:0]            ctrl;
    logic [7:0]            budget;
    logic                  bit_tick;
    slt_pkg::slt_tx_state_t txs;
    logic [11:0]           sh;
    logic                  ser;
    logic [11:0]           enc_ch;
    logic                  enc_cmd;
    logic                  rd;
    logic                  lf;
    logic                  trk;
    logic                  rxck;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } slt_top_st_t;

  slt_top_st_t st_ff;
  slt_top_st_t nxt_st;

  logic [7:0]  pins;
  logic        ref_rise;
  logic        halt_s;
  logic        eff_range;
  logic        coded12;
  logic        fifo_on;
  logic        enc_on;
  logic        accept;
  logic [7:0]  mult_hu;
  logic [7:0]  bud_sum;
  logic [3:0]  len;
  logic [11:0] len_mask;
  logic [11:0] sync_now;
  logic [11:0] tx_pick;
  logic        tx_pick_cmd;
  logic        tx_char_tick;
  logic        rx_char_tick;
  logic [3:0]  tx_cnt;
  logic [3:0]  rx_cnt;
  logic        rx_bit;
  logic [11:0] rx_ch;
  logic        rx_vld;
  logic        sig_good;
  logic [2:0]  rd_sel;
  slt_pkg::slt_tx_state_t txs_nxt;

  // Pin order in the synchroniser: ref, pri, sec, halt, amp, dens, carr, freq
  assign pins = {reference_clock, serial_in_primary, serial_in_secondary,
                 tx_halt_a, sig_amplitude_ok, sig_density_ok,
                 sig_carrier_ok, sig_freq_ok};

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == slt_pkg::ADDR_CTRL) begin
      reg_sel = 3'h1;
    end else if (a == slt_pkg::ADDR_STAT) begin
      reg_sel = 3'h2;
    end else if (a == slt_pkg::ADDR_RXCH) begin
      reg_sel = 3'h3;
    end else if (a == slt_pkg::ADDR_TXCH) begin
      reg_sel = 3'h4;
    end else begin
      reg_sel = 3'h0;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  assign fifo_on  = st_ff.ctrl[slt_pkg::CTRL_FIFOBYN];
  assign enc_on   = st_ff.ctrl[slt_pkg::CTRL_ENCBYN];
  assign len      = st_ff.ctrl[slt_pkg::CTRL_CWIDTH] ? slt_pkg::LEN_10
                                                     : slt_pkg::LEN_12;
  assign len_mask = (len == slt_pkg::LEN_12) ? 12'hFFF : 12'h3FF;
  assign sync_now = st_ff.ctrl[slt_pkg::CTRL_CWIDTH] ? {2'h0, SYNC_10B}
                                                     : SYNC_12B;
  assign eff_range = st_ff.ctrl[slt_pkg::CTRL_RANGE]
                   & (st_ff.ctrl[slt_pkg::CTRL_SPEED] | fifo_on);
  assign coded12 = !st_ff.ctrl[slt_pkg::CTRL_CWIDTH] && !enc_on;

  always_comb begin
    if (st_ff.ctrl[slt_pkg::CTRL_SPEED] && !eff_range) begin
      mult_hu = coded12 ? slt_pkg::HU_12X : slt_pkg::HU_10X;
    end else if (!st_ff.ctrl[slt_pkg::CTRL_SPEED] && eff_range) begin
      mult_hu = coded12 ? slt_pkg::HU_3X : slt_pkg::HU_25X;
    end else begin
      mult_hu = coded12 ? slt_pkg::HU_6X : slt_pkg::HU_5X;
    end
  end

  // Only the second synchroniser stage is ever read
  assign ref_rise = st_ff.sy2[7] & ~st_ff.ref_d;
  assign halt_s   = st_ff.sy2[4] & fifo_on;
  assign bud_sum  = st_ff.budget + (ref_rise ? mult_hu : 8'h00);
  assign accept   = tx_write_enable & ~tx_full_flag;

  assign rx_bit = st_ff.ctrl[slt_pkg::CTRL_LOOP]    ? st_ff.ser :
                  st_ff.ctrl[slt_pkg::CTRL_LINESEL] ? st_ff.sy2[5]
                                                    : st_ff.sy2[6];
  assign sig_good = &st_ff.sy2[3:0];

  // ----------------------------------------------------------------------
  // Dividers and framer
  // ----------------------------------------------------------------------
  // char clock from the multiplier
  slt_char_div u_tx_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .bit_tick  (st_ff.bit_tick),
    .len       (len),
    .cnt       (tx_cnt),
    .char_tick (tx_char_tick)
  );

  slt_char_div u_rx_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .bit_tick  (st_ff.bit_tick),
    .len       (len),
    .cnt       (rx_cnt),
    .char_tick (rx_char_tick)
  );

  slt_framer u_framer (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .bit_tick   (st_ff.bit_tick),
    .bit_in     (rx_bit),
    .enable     (st_ff.ctrl[slt_pkg::CTRL_FRAMEN]),
    .len        (len),
    .cnt        (rx_cnt),
    .char_tick  (rx_char_tick),
    .sync_pat   (sync_now),
    .char_out   (rx_ch),
    .char_valid (rx_vld)
  );

  // ----------------------------------------------------------------------
  // Transmit choice for the coming character slot
  // ----------------------------------------------------------------------
  always_comb begin
    tx_pick     = sync_now;
    tx_pick_cmd = 1'b1;
    txs_nxt     = !fifo_on ? slt_pkg::TX_BYPASS :
                  halt_s   ? slt_pkg::TX_HALTED : slt_pkg::TX_FIFO;
    case (txs_nxt)
      slt_pkg::TX_BYPASS: begin
        if (accept) begin
          tx_pick     = tx_parallel_data & len_mask;
          tx_pick_cmd = tx_parallel_cmd;
        end
      end
      slt_pkg::TX_HALTED: begin
        tx_pick_cmd = 1'b1;
      end
      default: begin
        if (!tx_fifo_empty) begin
          tx_pick     = tx_fifo_data & len_mask;
          tx_pick_cmd = tx_fifo_cmd;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st.sy1 = pins;
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.ref_d = st_ff.sy2[7];
    nxt_st.ctrl = st_ff.ctrl;
    nxt_st.txs = txs_nxt;
    nxt_st.bit_tick = (bud_sum >= slt_pkg::HU_PERBIT);
    nxt_st.budget = nxt_st.bit_tick ? bud_sum - slt_pkg::HU_PERBIT : bud_sum;
    nxt_st.sh = st_ff.sh;
    nxt_st.ser = st_ff.ser;
    nxt_st.enc_ch = st_ff.enc_ch;
    nxt_st.enc_cmd = st_ff.enc_cmd;
    nxt_st.rd = 1'b0;
    nxt_st.lf = st_ff.lf;
    nxt_st.trk = ~st_ff.sy2[0];
    nxt_st.rxck = !fifo_on && (rx_cnt < (len >> 1));
    if (st_ff.bit_tick) begin
      nxt_st.ser = st_ff.sh[0];
      nxt_st.sh = st_ff.sh >> 1;
    end
    if (tx_char_tick) begin
      nxt_st.enc_ch = tx_pick;
      nxt_st.enc_cmd = tx_pick_cmd;
      nxt_st.rd = (nxt_st.txs == slt_pkg::TX_FIFO) && !tx_fifo_empty;
      // encoder code, or raw character or sync, into shifter
      nxt_st.sh = enc_on ? (enc_code_in & len_mask) : tx_pick;
    end
    // fault moves only on rx char clock
    if (rx_char_tick) begin
      nxt_st.lf = ~sig_good;
    end
    // APB: no wait state, read data latched at the setup edge, write at the access edge
    rd_sel = reg_sel(paddr);
    nxt_st.pready = psel && !penable && !st_ff.pready;
    nxt_st.pslverr = nxt_st.pready && (rd_sel == 3'h0);
    nxt_st.prdata = st_ff.prdata;
    if (nxt_st.pready) begin
      if (pwrite || rd_sel == 3'h0) begin
        nxt_st.prdata = 32'h0000_0000;
      end else if (rd_sel == 3'h1) begin
        nxt_st.prdata = {24'h00_0000, st_ff.ctrl};
      end else if (rd_sel == 3'h2) begin
        nxt_st.prdata = {19'h0_0000, mult_hu[4:0], 5'h00,
                         st_ff.txs == slt_pkg::TX_HALTED, st_ff.trk,
                         st_ff.lf};
      end else if (rd_sel == 3'h3) begin
        nxt_st.prdata = {20'h0_0000, rx_ch};
      end else begin
        nxt_st.prdata = {20'h0_0000, st_ff.enc_ch};
      end
    end
    if (psel && penable && st_ff.pready && pwrite && rd_sel == 3'h1) begin
      nxt_st.ctrl = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.ctrl <= slt_pkg::CTRL_RESET;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata        = st_ff.prdata;
  assign pready        = st_ff.pready;
  assign pslverr       = st_ff.pslverr;
  assign tx_fifo_read  = st_ff.rd;
  assign enc_char      = st_ff.enc_ch;
  assign enc_is_cmd    = st_ff.enc_cmd;
  assign serial_out    = st_ff.ser;
  assign rx_char_clock = st_ff.rxck;
  assign rx_char_out   = rx_ch;
  assign rx_char_valid = rx_vld;
  assign link_fault    = st_ff.lf;
  assign cdr_track_ref = st_ff.trk;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bit_budget: assert property (
    ce && ref_rise && st_ff.budget == 8'h00
    |=> st_ff.bit_tick && st_ff.budget == $past(mult_hu) - 8'h02)
    else $error("multiplier budget wrong after reference edge");

  a_read_on_tick: assert property (
    ce && !tx_char_tick |=> !st_ff.rd)
    else $error("FIFO read outside a character slot");

  a_range_ignored: assert property (
    !fifo_on && !st_ff.ctrl[slt_pkg::CTRL_SPEED]
    |-> mult_hu == slt_pkg::HU_5X || mult_hu == slt_pkg::HU_6X)
    else $error("range select honoured in bypass at low speed");

  a_bypass_sync: assert property (
    ce && tx_char_tick && !fifo_on && !accept
    |=> st_ff.enc_cmd && st_ff.enc_ch == $past(sync_now))
    else $error("no sync command on empty bypass slot");

  a_raw_sync: assert property (
    ce && tx_char_tick && !enc_on && fifo_on && tx_fifo_empty
    |=> st_ff.sh == $past(sync_now))
    else $error("raw sync not loaded into shifter");

  a_halt_ignored: assert property (
    ce && tx_char_tick && !fifo_on && accept
    |=> st_ff.enc_ch == ($past(tx_parallel_data) & $past(len_mask)))
    else $error("bypass data lost or halted");

  a_halt_no_read: assert property (
    ce && tx_char_tick && halt_s |=> !st_ff.rd ##0 st_ff.enc_cmd)
    else $error("FIFO read while halted");

  a_lsb_first: assert property (
    ce && st_ff.bit_tick |=> st_ff.ser == $past(st_ff.sh[0]))
    else $error("serial bit is not the shifter LSB");

  a_fault_hold: assert property (
    ce && !rx_char_tick |=> $stable(st_ff.lf))
    else $error("link fault changed off the character clock");

  a_fault_level: assert property (
    ce && rx_char_tick |=> st_ff.lf == !$past(sig_good))
    else $error("link fault does not follow signal detect");

  a_loop_src: assert property (
    st_ff.ctrl[slt_pkg::CTRL_LOOP] |-> rx_bit == st_ff.ser)
    else $error("loopback does not feed the receiver");

endmodule

// *** verif/slt_remote_model.sv ***
// Far end of the link: reference oscillator and a remote serial stream.
// Assumes the top module only reads these outputs.
module slt_remote_model;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic line;
  // ---------------------------------------------
  // Reference and line
  // ---------------------------------------------
  // Scaled slow reference keeps bit rate below pclk
  initial begin
    ref_clk = 1'b0;
    forever #100 ref_clk = ~ref_clk;
  end
  // No halt back-pressure from this end
  // Line never rests, so stale levels cannot pass as data
  initial begin
    line = 1'b0;
    forever #30 line = ~line;
  end
endmodule

// *** verif/test_serial_link_tx_control_rx_framer.sv ***
// Bench for slt_top: APB master, link stimulus, loopback framing.
// Assumes the remote model supplies reference clock and line.
module test_serial_link_tx_control_rx_framer;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic halt, amp, dens, wen, full, empty, rdy, cmd, valid, fault, trk;
  logic ser, rxc, er;
  logic [11:0] txd, enc, rxo;
  int num_errors, n_checks, cyc, k;
  slt_remote_model far();
  slt_top dut(.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_clock(far.ref_clk), .serial_in_primary(1'b0),
    .serial_in_secondary(far.line), .tx_halt_a(halt),
    .sig_amplitude_ok(amp), .sig_density_ok(dens), .sig_carrier_ok(amp),
    .sig_freq_ok(amp), .tx_parallel_data(txd), .tx_parallel_cmd(1'b0),
    .tx_write_enable(wen), .tx_full_flag(full), .tx_fifo_data(txd),
    .tx_fifo_cmd(1'b0), .tx_fifo_empty(empty), .tx_fifo_read(rdy),
    .enc_char(enc), .enc_is_cmd(cmd), .enc_code_in(enc),
    .serial_out(ser), .rx_char_clock(rxc), .rx_char_out(rxo),
    .rx_char_valid(valid), .link_fault(fault), .cdr_track_ref(trk));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("unexpected %s exp %h got %h", n, e, s);
      num_errors++;
    end
  endtask
  // Holds the request until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_regs;
    apb(0, slt_pkg::ADDR_CTRL, 0);
    chk("ctrl", 32'h1C, rd);
    apb(0, 8'h10, 0);
    chk("slverr", 1, er);
    apb(1, slt_pkg::ADDR_CTRL, 32'h08);
    apb(0, slt_pkg::ADDR_CTRL, 0);
    chk("ctrl_wr", 32'h08, rd);
    apb(0, slt_pkg::ADDR_STAT, 0);
    chk("mult12", slt_pkg::HU_6X, rd[12:8]);
    apb(1, slt_pkg::ADDR_CTRL, 32'h1C);
  endtask
  task t_fault;
    chk("track_bad", 1, trk);
    chk("primary_line", 0, rxo);
    amp <= 1'b1;
    dens <= 1'b1;
    repeat (600) @(posedge pclk);
    chk("fault_ok", 0, fault);
    chk("track_ok", 0, trk);
    dens <= 1'b0;
    repeat (600) @(posedge pclk);
    chk("fault_bad", 1, fault);
    apb(1, slt_pkg::ADDR_CTRL, 32'h5C);
    dens <= 1'b1;
    repeat (600) @(posedge pclk);
    chk("secondary_line", 1, rxo != 0);
    chk("fault_clear", 0, fault);
    apb(1, slt_pkg::ADDR_CTRL, 32'h1C);
  endtask
  task t_halt;
    halt <= 1'b1;
    empty <= 1'b0;
    repeat (8) @(posedge pclk);
    k = 0;
    repeat (400) @(posedge pclk) k += rdy;
    chk("halt_reads", 0, k);
    apb(0, slt_pkg::ADDR_STAT, 0);
    chk("halted", 1, rd[2]);
    halt <= 1'b0;
    k = 0;
    repeat (400) @(posedge pclk) k += rdy;
    chk("resume_reads", 1, k != 0);
    empty <= 1'b1;
    repeat (400) @(posedge pclk);
    chk("empty_sync", slt_top_sync(), enc[9:0]);
  endtask
  function logic [9:0] slt_top_sync();
    return 10'h0F8;
  endfunction
  task t_bypass;
    apb(1, slt_pkg::ADDR_CTRL, 32'h14);
    halt <= 1'b1;
    txd <= 12'h155;
    wen <= 1'b1;
    k = 0;
    repeat (400) @(posedge pclk) k += rxc;
    chk("rx_char_clock_runs", 1, k > 0 && k < 400);
    chk("byp_data", 10'h155, enc[9:0]);
    chk("byp_cmd", 0, cmd);
    apb(0, slt_pkg::ADDR_STAT, 0);
    chk("byp_halt", 0, rd[2]);
    full <= 1'b1;
    repeat (400) @(posedge pclk);
    chk("full_sync", slt_top_sync(), enc[9:0]);
    chk("full_cmd", 1, cmd);
  endtask
  task t_loop;
    apb(1, slt_pkg::ADDR_CTRL, 32'hBC);
    k = 0;
    repeat (3000) @(posedge pclk)
      if (valid === 1'b1 && rxo[9:0] === slt_top_sync()) k = 1;
    chk("framed_sync", 1, k);
  endtask
  initial begin
    presetn = 1'b0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; halt = 0; amp = 0; dens = 0; wen = 0; full = 0;
    empty = 1; txd = 0; cyc = 0; num_errors = 0; n_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_fault;
    t_halt;
    t_loop;
    t_bypass;
    end_of_test;
  end
endmodule
